// ---- rtl/ersi_consts.vh ----
// Constants for the speed sensor 2 input block
`ifndef ERSI_CONSTS_VH
`define ERSI_CONSTS_VH
`define ERSI_MODE_OFF       16'h0000
`define ERSI_MODE_QUAD      16'h0004
`define ERSI_MODE_QUAD_INV  16'h0068
`define ERSI_MODE_QREF      16'h03EC
`define ERSI_MODE_QREF_INV  16'h0450
`define ERSI_MODE_RES       16'h2710
`define ERSI_MODE_RES_INV   16'h2774
`define ERSI_SETUP_TUNE     16'h0226
`define ERSI_MARKS_MIN      14'h0001
`define ERSI_MARKS_MAX      14'h2000
`define ERSI_MARKS_RST      14'h0400
`define ERSI_POLE_MIN       3'h1
`define ERSI_POLE_MAX       3'h7
`define ERSI_POLE_RST       3'h1
`define ERSI_OFS_MAX        16'h0E10
`define ERSI_OFS_RST        16'h0000
`define ERSI_FAULT_DIR      16'h1420
`define ERSI_GATE_US        2000
`define ERSI_CLK_MHZ        100
`define ERSI_GATE_CYC       (`ERSI_GATE_US * `ERSI_CLK_MHZ)
`define ERSI_TUNE_CYC       (`ERSI_GATE_CYC * 4)
`define ERSI_ST_IDLE        6'h01
`define ERSI_ST_STO         6'h02
`define ERSI_ST_RUN         6'h04
`define ERSI_ST_DONE        6'h08
`define ERSI_ST_FAULT       6'h10
`define ERSI_ST_RESET       6'h20
`endif

// ---- rtl/ersi_speed_input.v ----
// Speed sensor input 2: quadrature encoder or resolver evaluation with offset tuning
// How it works
// - Mode zero: no measurement, no speed reported
// - Mode 4: quadrature decode, direction, four edges
// - Mode 104: like mode 4, speed negated
// - Mode 1004: quadrature plus reference pulse monitoring
// - Mode 1104: like 1004, speed negated
// - Mode 10000: resolver angle and speed from sin/cos
// - Mode 10100: resolver evaluation, speed negated
// - Always four edges per mark, fixed
// - Marks per revolution 1..8192, default 1024
// - Electrical angle wraps once per pole pair
// - Pole pairs 1..7, default 1, scale angle
// - Signed offset -360..360 deg, default zero
// - Setup value 550 starts offset tuning, in the resolver modes only
// - Report tuning status; partner gives torque release
// - Valid offset stored in the same cycle as the device reset pulse
// - Direction mismatch aborts with fault 5152 (1420 hex)
`timescale 1ns/1ps
`include "ersi_consts.vh"
module ersi_speed_input #(
	parameter integer GATE_CYC = `ERSI_GATE_CYC,
	parameter integer TUNE_CYC = `ERSI_TUNE_CYC
) (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        clk_en_i,
	input  wire [15:0] op_mode_i,
	input  wire [13:0] marks_per_revolution_i,
	input  wire [2:0]  resolver_pole_pair_count_i,
	input  wire [15:0] resolver_angle_offset_i,
	input  wire        offset_write_i,
	input  wire [15:0] setup_select_i,
	input  wire        setup_write_i,
	input  wire        track_a_i,
	input  wire        track_b_i,
	input  wire        track_ref_i,
	input  wire        res_sin_ge0_i,
	input  wire        res_cos_ge0_i,
	input  wire [15:0] res_elec_angle_i,
	input  wire        safe_torque_off_release_i,
	input  wire        motor_dir_neg_i,
	output reg  [31:0] speed_o,
	output reg         speed_valid_o,
	output reg  [31:0] position_o,
	output reg  [15:0] mech_angle_o,
	output reg  [15:0] offset_o,
	output reg  [5:0]  setup_status_o,
	output reg  [15:0] fault_code_o,
	output reg         ref_error_o,
	output reg         device_reset_o
);

	localparam [5:0] ST_IDLE  = `ERSI_ST_IDLE;
	localparam [5:0] ST_STO   = `ERSI_ST_STO;
	localparam [5:0] ST_RUN   = `ERSI_ST_RUN;
	localparam [5:0] ST_DONE  = `ERSI_ST_DONE;
	localparam [5:0] ST_FAULT = `ERSI_ST_FAULT;
	localparam [5:0] ST_RESET = `ERSI_ST_RESET;

	// Mode decode used by both the speed path and the sign stage
	function [2:0] mode_dec;
		input [15:0] m;
		begin
			case (m)
				`ERSI_MODE_QUAD:     mode_dec = 3'h1;
				`ERSI_MODE_QUAD_INV: mode_dec = 3'h1 | 3'h4;
				`ERSI_MODE_QREF:     mode_dec = 3'h1;
				`ERSI_MODE_QREF_INV: mode_dec = 3'h1 | 3'h4;
				`ERSI_MODE_RES:      mode_dec = 3'h2;
				`ERSI_MODE_RES_INV:  mode_dec = 3'h2 | 3'h4;
				default:             mode_dec = 3'h0;
			endcase
		end
	endfunction

	wire [2:0] md      = mode_dec(op_mode_i);
	wire       enc_on  = md[0];
	wire       res_on  = md[1];
	wire       inv     = md[2];
	// Reference monitoring runs only in the two modes that ask for it
	wire       ref_on  = (op_mode_i == `ERSI_MODE_QREF) || (op_mode_i == `ERSI_MODE_QREF_INV);

	// Clock enable low freezes every register; pins are not sampled then
	// Two-stage synchronisers; stage one feeds stage two only
	// The reference pulse is synchronised with the tracks so its count lines up
	reg [5:0] sy1_q;
	reg [5:0] sy2_q;
	reg [5:0] prev_q;
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sy1_q  <= 6'h00;
			sy2_q  <= 6'h00;
			prev_q <= 6'h00;
		end
		else if (clk_en_i)
		begin
			sy1_q  <= {track_ref_i,
				safe_torque_off_release_i,
				res_cos_ge0_i,
				res_sin_ge0_i,
				track_b_i,
				track_a_i};
			sy2_q  <= sy1_q;
			prev_q <= sy2_q;
		end
	end

	wire a_s = sy2_q[0];
	wire b_s = sy2_q[1];
	wire r_s = sy2_q[5];
	wire sto_s = sy2_q[4];

	// Quadrature step: +1, -1 or 0; both tracks toggling is dropped as a glitch
	// A skipped quadrant on both tracks is lost rather than guessed
	wire       a_chg = a_s ^ prev_q[0];
	wire       b_chg = b_s ^ prev_q[1];
	wire       qstep = enc_on && (a_chg ^ b_chg);
	wire       qup   = a_chg ? (a_s ^ b_s) : ~(a_s ^ b_s);

	// Resolver quadrant step from sin/cos sign bits, same Gray sequence
	wire       s_chg = sy2_q[2] ^ prev_q[2];
	wire       c_chg = sy2_q[3] ^ prev_q[3];
	wire       rstep = res_on && (s_chg ^ c_chg);
	wire       rup   = c_chg ? (sy2_q[3] ^ sy2_q[2]) : ~(sy2_q[3] ^ sy2_q[2]);

	wire       step = qstep | rstep;
	wire       up   = qstep ? qup : rup;

	// Clamp of settings into their legal ranges
	// Out of range marks and pole counts are clamped; out of range offset writes are refused
	wire [13:0] marks = (marks_per_revolution_i < `ERSI_MARKS_MIN) ? `ERSI_MARKS_MIN :
		(marks_per_revolution_i > `ERSI_MARKS_MAX) ? `ERSI_MARKS_MAX :
		marks_per_revolution_i;
	wire [2:0]  poles = (resolver_pole_pair_count_i < `ERSI_POLE_MIN) ? `ERSI_POLE_MIN :
		resolver_pole_pair_count_i;
	wire [15:0] edges_rev = {marks, 2'b00};

	reg  [15:0] pos_in_rev_q;
	reg  [15:0] turns_q;
	reg  [31:0] gate_q;
	reg  signed [31:0] acc_q;
	reg  [15:0] ref_pos_q;
	reg         ref_seen_q;
	reg         r_prev_q;
	wire        r_rise = r_s & ~r_prev_q;

	// Resolver steps never wrap the in-turn count; only the encoder has a marked turn
	// Position count and gated speed measurement in edges per gate window
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pos_in_rev_q  <= 16'h0000;
			turns_q       <= 16'h0000;
			gate_q        <= 32'h0000_0000;
			acc_q         <= 32'sh0000_0000;
			speed_o       <= 32'h0000_0000;
			speed_valid_o <= 1'b0;
			position_o    <= 32'h0000_0000;
			ref_pos_q     <= 16'h0000;
			ref_seen_q    <= 1'b0;
			r_prev_q      <= 1'b0;
			ref_error_o   <= 1'b0;
		end
		else if (clk_en_i)
		begin
			r_prev_q <= r_s;
			if (!enc_on && !res_on)
			begin
				gate_q        <= 32'h0000_0000;
				acc_q         <= 32'sh0000_0000;
				speed_o       <= 32'h0000_0000;
				speed_valid_o <= 1'b0;
				ref_seen_q    <= 1'b0;
			end
			else
			begin
				if (step)
				begin
					if (up)
					begin
						acc_q <= acc_q + 32'sh0000_0001;
						if (qstep && pos_in_rev_q == edges_rev - 16'h0001)
						begin
							pos_in_rev_q <= 16'h0000;
							turns_q      <= turns_q + 16'h0001;
						end
						else
							pos_in_rev_q <= pos_in_rev_q + 16'h0001;
					end
					else
					begin
						acc_q <= acc_q - 32'sh0000_0001;
						if (qstep && pos_in_rev_q == 16'h0000)
						begin
							pos_in_rev_q <= edges_rev - 16'h0001;
							turns_q      <= turns_q - 16'h0001;
						end
						else
							pos_in_rev_q <= pos_in_rev_q - 16'h0001;
					end
				end
				// Reference pulse must land on the same count every turn
				// The first pulse only records where the turn starts
				if (ref_on && r_rise)
				begin
					ref_seen_q <= 1'b1;
					ref_pos_q  <= pos_in_rev_q;
					if (ref_seen_q && pos_in_rev_q != ref_pos_q)
						ref_error_o <= 1'b1;
				end
				// Speed is edges per gate; the window matches the slowest useful edge rate
				if (gate_q >= GATE_CYC - 1)
				begin
					gate_q        <= 32'h0000_0000;
					acc_q         <= 32'sh0000_0000;
					speed_o       <= inv ? -acc_q : acc_q;
					speed_valid_o <= 1'b1;
				end
				else
					gate_q <= gate_q + 32'h0000_0001;
			end
			position_o <= {turns_q, pos_in_rev_q};
			if (!ref_on)
				ref_error_o <= 1'b0;
		end
	end

	// Mechanical angle: electrical angle plus offset, divided by pole pairs
	// The offset is applied before the pole divide, in electrical degrees
	wire signed [17:0] ang_sum = $signed({2'b00, res_elec_angle_i}) + $signed({{2{offset_o[15]}},
		offset_o});
	wire [15:0] ang_wrap = ang_sum[15:0];
	wire [15:0] pp_turn;
	assign pp_turn = turns_q % {13'h0000, poles};
	// The divide is combinational; it stays cheap only because the pole count is 3 bits
	wire [18:0] mech_raw = {pp_turn[2:0], ang_wrap};
	wire [18:0] mech_div = mech_raw / {16'h0000, poles};

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mech_angle_o <= 16'h0000;
		else if (clk_en_i)
			mech_angle_o <= res_on ? mech_div[15:0] : 16'h0000;
	end

	// Offset tuning sequencer
	reg [5:0]  st_q;
	reg [31:0] tcnt_q;
	reg [15:0] tune_ofs_q;
	reg signed [15:0] dir_acc_q;
	wire ofs_ok = ($signed(resolver_angle_offset_i) <= $signed(`ERSI_OFS_MAX)) &&
		($signed(resolver_angle_offset_i) >= -$signed(`ERSI_OFS_MAX));

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q           <= ST_IDLE;
			tcnt_q         <= 32'h0000_0000;
			tune_ofs_q     <= 16'h0000;
			dir_acc_q      <= 16'sh0000;
			offset_o       <= `ERSI_OFS_RST;
			fault_code_o   <= 16'h0000;
			device_reset_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			device_reset_o <= 1'b0;
			// Offset writes are dropped while tuning so the tuned value is not overwritten
			if (offset_write_i && ofs_ok && st_q == ST_IDLE)
				offset_o <= resolver_angle_offset_i;
			case (st_q)
				ST_IDLE:
					if (setup_write_i && setup_select_i == `ERSI_SETUP_TUNE && res_on)
					begin
						st_q         <= ST_STO;
						fault_code_o <= 16'h0000;
					end
				ST_STO:
					if (sto_s)
					begin
						st_q      <= ST_RUN;
						tcnt_q    <= 32'h0000_0000;
						dir_acc_q <= 16'sh0000;
					end
				ST_RUN:
				begin
					// Tuning counts resolver quadrant steps only; the sign follows the mode
					if (rstep)
						dir_acc_q <= (rup ^ inv) ? dir_acc_q + 16'sh0001 : dir_acc_q - 16'sh0001;
					// Capture the negated electrical angle at which the rotor settled
					tune_ofs_q <= 16'h0000 - res_elec_angle_i;
					if (!sto_s)
						st_q <= ST_STO;
					else if (tcnt_q >= TUNE_CYC - 1)
					begin
						if ((dir_acc_q < 0) != motor_dir_neg_i && dir_acc_q != 0)
						begin
							st_q         <= ST_FAULT;
							fault_code_o <= `ERSI_FAULT_DIR;
						end
						else
							st_q <= ST_DONE;
					end
					else
						tcnt_q <= tcnt_q + 32'h0000_0001;
				end
				ST_DONE:
				begin
					offset_o <= tune_ofs_q;
					st_q     <= ST_RESET;
					// Reset pulse rises with the reset state so both are seen together
					device_reset_o <= 1'b1;
				end
				ST_RESET:
				begin
					st_q           <= ST_IDLE;
				end
				// A fault holds until software writes the setup selection again
				ST_FAULT:
					if (setup_write_i)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// Status is the state code itself, so software sees each step as it happens
	always @*
	begin
		setup_status_o = st_q;
	end

endmodule // ersi_speed_input

// ---- sim/ersi_shaft_model.sv ----
// Shaft sensor model: quadrature tracks, reference pulse, resolver quadrants
`timescale 1ns/1ps
module ersi_shaft_model (
	input  wire        clk_i,
	input  wire        step_i,
	input  wire        back_i,
	input  wire        glitch_i,
	output wire        track_a_o,
	output wire        track_b_o,
	output wire        ref_o,
	output wire        sin_ge0_o,
	output wire        cos_ge0_o,
	output wire [15:0] angle_o
);
	reg [15:0] cnt_q = 16'h0000;
	// A glitch jumps two quadrants so both tracks flip at once
	always @(posedge clk_i)
		cnt_q <= cnt_q + (glitch_i ? 16'h0002 : step_i ? (back_i ? 16'hFFFF : 16'h0001) : 16'h0000);
	assign track_a_o = cnt_q[1] ^ cnt_q[0];
	assign track_b_o = cnt_q[1];
	assign ref_o     = (cnt_q[11:0] == 12'h000);
	assign sin_ge0_o = ~cnt_q[1];
	assign cos_ge0_o = ~(cnt_q[1] ^ cnt_q[0]);
	assign angle_o   = {cnt_q[1:0], 14'h0000};
endmodule // ersi_shaft_model

// ---- sim/ersi_speed_input_properties.sv ----
// Checker for the speed sensor 2 input block
`timescale 1ns/1ps
`include "ersi_consts.vh"
module ersi_speed_input_chk (
	input wire        sys_clk_i,
	input wire        rst_i,
	input wire [15:0] op_mode_i,
	input wire [15:0] resolver_angle_offset_i,
	input wire        offset_write_i,
	input wire [15:0] setup_select_i,
	input wire        setup_write_i,
	input wire        safe_torque_off_release_i,
	input wire        speed_valid_o,
	input wire [15:0] mech_angle_o,
	input wire [15:0] offset_o,
	input wire [5:0]  setup_status_o,
	input wire [15:0] fault_code_o,
	input wire        device_reset_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire res_m = op_mode_i == `ERSI_MODE_RES || op_mode_i == `ERSI_MODE_RES_INV;
	wire go = setup_write_i && setup_select_i == `ERSI_SETUP_TUNE && setup_status_o == `ERSI_ST_IDLE;
	wire bad_ofs = $signed(resolver_angle_offset_i) > 3600 || $signed(resolver_angle_offset_i) < -3600;
	a_off_invalid: assert property ((op_mode_i == `ERSI_MODE_OFF)[*3] |-> !speed_valid_o)
		else $error("speed valid while off");
	a_mech_zero: assert property ((!res_m)[*3] |-> mech_angle_o == 16'h0000)
		else $error("angle outside resolver mode");
	a_ofs_refused: assert property (offset_write_i && bad_ofs && setup_status_o == `ERSI_ST_IDLE
		|=> $stable(offset_o))
		else $error("out of range offset taken");
	a_tune_start: assert property (go && res_m |=> setup_status_o == `ERSI_ST_STO)
		else $error("tuning not started");
	a_tune_refused: assert property (go && !res_m |=> setup_status_o == `ERSI_ST_IDLE)
		else $error("tuning started outside resolver mode");
	a_sto_wait: assert property ((!safe_torque_off_release_i)[*3] ##0 setup_status_o == `ERSI_ST_STO
		|=> setup_status_o != `ERSI_ST_RUN)
		else $error("run without torque release");
	a_status_onehot: assert property ($onehot(setup_status_o))
		else $error("status not one-hot");
	a_reset_order: assert property (device_reset_o |-> setup_status_o == `ERSI_ST_RESET
		&& $past(setup_status_o) == `ERSI_ST_DONE)
		else $error("device reset out of order");
	a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
		else $error("device reset longer than one cycle");
	a_fault_code: assert property (setup_status_o == `ERSI_ST_FAULT |-> fault_code_o == `ERSI_FAULT_DIR)
		else $error("wrong fault code");
	c_tune: cover property (device_reset_o);
	c_fault: cover property (setup_status_o == `ERSI_ST_FAULT);
	c_refuse: cover property (go && !res_m);
endmodule // ersi_speed_input_chk
bind ersi_speed_input ersi_speed_input_chk u_chk (.sys_clk_i, .rst_i, .op_mode_i,
	.resolver_angle_offset_i, .offset_write_i, .setup_select_i, .setup_write_i,
	.safe_torque_off_release_i, .speed_valid_o, .mech_angle_o, .offset_o, .setup_status_o,
	.fault_code_o, .device_reset_o);

// ---- sim/test_ersi_speed_input.sv ----
// Testbench for the speed sensor 2 input block
`timescale 1ns/1ps
`include "ersi_consts.vh"
module test_ersi_speed_input;
	reg         sys_clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg  [15:0] mode = 16'h0000;
	reg  [15:0] ofs = 16'h0000;
	reg  [15:0] sel = 16'h0000;
	reg         ofs_wr = 1'b0;
	reg         sel_wr = 1'b0;
	reg         safe_torque_off_release = 1'b0;
	reg         dir_neg = 1'b0;
	reg         step = 1'b0;
	reg         back = 1'b0;
	reg         glitch = 1'b0;
	wire        ta, tb, tr, sn, cs, vld, ref_err, dev_rst;
	wire [15:0] ang, mech, ofs_o, fcode;
	wire [31:0] spd, pos;
	wire [5:0]  st;
	reg  [31:0] p0;
	integer     failures = 0;
	integer     tests_run = 0;
	integer     i;
	always #5 sys_clk_i = ~sys_clk_i;
	// Shortened windows keep the run short
	ersi_speed_input #(.GATE_CYC(400), .TUNE_CYC(4000)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.clk_en_i(1'b1), .op_mode_i(mode), .marks_per_revolution_i(`ERSI_MARKS_RST),
		.resolver_pole_pair_count_i(`ERSI_POLE_RST), .resolver_angle_offset_i(ofs),
		.offset_write_i(ofs_wr), .setup_select_i(sel), .setup_write_i(sel_wr), .track_a_i(ta),
		.track_b_i(tb), .track_ref_i(tr), .res_sin_ge0_i(sn), .res_cos_ge0_i(cs),
		.res_elec_angle_i(ang), .safe_torque_off_release_i(safe_torque_off_release), .motor_dir_neg_i(dir_neg),
		.speed_o(spd), .speed_valid_o(vld), .position_o(pos), .mech_angle_o(mech),
		.offset_o(ofs_o), .setup_status_o(st), .fault_code_o(fcode), .ref_error_o(ref_err),
		.device_reset_o(dev_rst));
	ersi_shaft_model u_shaft (.clk_i(sys_clk_i), .step_i(step), .back_i(back), .glitch_i(glitch),
		.track_a_o(ta), .track_b_o(tb), .ref_o(tr), .sin_ge0_o(sn), .cos_ge0_o(cs), .angle_o(ang));
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] name);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("BAD %0s exp %0h seen %0h", name, exp, seen);
		end
	end
	endtask
	task cyc(input integer n);
	begin
		repeat (n) @(posedge sys_clk_i);
		#1;
	end
	endtask
	// 90 cycles an edge keeps tracks under the input frequency limit
	task mv(input integer n, input bk);
	begin
		repeat (n)
		begin
			back = bk;
			step = 1'b1;
			cyc(1);
			step = 1'b0;
			cyc(89);
		end
	end
	endtask
	task pulse_sel(input [15:0] v);
	begin
		sel = v;
		sel_wr = 1'b1;
		cyc(1);
		sel_wr = 1'b0;
	end
	endtask
	task wt(input [5:0] s);
		integer n;
	begin
		n = 0;
		while (st === s && n < 5000)
		begin
			cyc(1);
			n = n + 1;
		end
	end
	endtask
	task t_quad;
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			mode = (i == 0) ? `ERSI_MODE_QUAD : (i == 1) ? `ERSI_MODE_QUAD_INV :
				(i == 2) ? `ERSI_MODE_QREF : `ERSI_MODE_QREF_INV;
			p0 = pos;
			mv(8, 1'b0);
			if (!i[0])
				chk(pos - p0, 32'h8, "fwd");
			mv(12, 1'b0);
			chk({31'h0, spd[31]}, {31'h0, i[0]}, "sign");
			chk({31'h0, vld}, 32'h1, "valid");
			p0 = pos;
			glitch = 1'b1;
			cyc(1);
			glitch = 1'b0;
			cyc(8);
			chk(pos - p0, 32'h0, "glitch");
			mv(4, 1'b1);
			if (!i[0])
				chk(pos - p0, 32'hFFFFFFFC, "back");
			chk({31'h0, ref_err}, 32'h0, "ref_err");
		end
		$display("quad test done");
	end
	endtask
	task t_res;
	begin
		mode = `ERSI_MODE_RES;
		mv(12, 1'b0);
		chk({31'h0, spd[31]}, 32'h0, "res");
		chk({16'h0, mech}, {16'h0, ang}, "mech");
		mode = `ERSI_MODE_RES_INV;
		mv(12, 1'b0);
		chk({31'h0, spd[31]}, 32'h1, "res_inv");
		chk({16'h0, mech}, {16'h0, ang}, "mech_inv");
		mode = `ERSI_MODE_OFF;
		cyc(3);
		chk({31'h0, vld}, 32'h0, "off_vld");
		chk(spd, 32'h0, "off_spd");
		chk({16'h0, mech}, 32'h0, "off_mech");
		$display("resolver test done");
	end
	endtask
	task t_ofs(input [15:0] v, input [15:0] exp);
	begin
		ofs = v;
		ofs_wr = 1'b1;
		cyc(1);
		ofs_wr = 1'b0;
		cyc(2);
		chk({16'h0, ofs_o}, {16'h0, exp}, "offset");
	end
	endtask
	task t_tune(input neg);
	begin
		mode = `ERSI_MODE_QUAD;
		pulse_sel(`ERSI_SETUP_TUNE);
		chk({26'h0, st}, {26'h0, `ERSI_ST_IDLE}, "refuse");
		mode = `ERSI_MODE_RES;
		dir_neg = neg;
		pulse_sel(`ERSI_SETUP_TUNE);
		chk({26'h0, st}, {26'h0, `ERSI_ST_STO}, "sto");
		safe_torque_off_release = 1'b1;
		wt(`ERSI_ST_STO);
		chk({26'h0, st}, {26'h0, `ERSI_ST_RUN}, "run");
		mv(32, 1'b0);
		wt(`ERSI_ST_RUN);
		if (neg)
		begin
			chk({26'h0, st}, {26'h0, `ERSI_ST_FAULT}, "fault");
			chk({16'h0, fcode}, {16'h0, `ERSI_FAULT_DIR}, "fcode");
			pulse_sel(16'h0000);
		end
		else
		begin
			chk({26'h0, st}, {26'h0, `ERSI_ST_DONE}, "done");
			wt(`ERSI_ST_DONE);
			chk({31'h0, dev_rst}, 32'h1, "devrst");
			chk({16'h0, ofs_o}, {16'h0, 16'h0000 - ang}, "tuned");
			cyc(1);
		end
		chk({26'h0, st}, {26'h0, `ERSI_ST_IDLE}, "idle");
		safe_torque_off_release = 1'b0;
		$display("tune test done");
	end
	endtask
	task results;
	begin
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		cyc(12);
		rst_i = 1'b0;
		cyc(1);
		chk({26'h0, st}, {26'h0, `ERSI_ST_IDLE}, "rst_st");
		t_quad;
		t_res;
		t_ofs(16'h0064, 16'h0064);
		t_ofs(16'h0FA0, 16'h0064);
		t_ofs(16'hF1F0, 16'hF1F0);
		t_tune(1'b1);
		t_tune(1'b0);
		results;
	end
	initial
	begin
		#600000;
		failures = failures + 1;
		results;
	end
endmodule // test_ersi_speed_input
